// >>> hdl/seq_ctl_pkg.sv
// package for the start-up / shutdown sequencer control block
// assumes a 25 MHz system clock and an Avalon-MM register slave
package seq_ctl_pkg;
   // ******************************
   // register map (byte addresses)
   // ******************************
   localparam logic [7:0] ADDR_IDENT = 8'h00;
   localparam logic [7:0] ADDR_SEQ0 = 8'h04;
   localparam logic [7:0] ADDR_SEQ1 = 8'h08;
   localparam logic [7:0] ADDR_SEQ2 = 8'h0c;
   localparam logic [7:0] ADDR_SEQ3 = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1c;
   localparam logic [7:0] ADDR_CAL = 8'h20;
   // ******************************
   // field layout and values
   // ******************************
   localparam int SEQ_ENA_BIT = 8;
   localparam int LAUNCH_BIT = 8;
   localparam int ABORT_BIT = 9;
   localparam int STEPS = 40;
   localparam logic [5:0] CAL_STEP = 6'h11;
   localparam logic [7:0] DUMMY_ADDR = 8'hff;
   localparam logic [5:0] SHUT_INDEX = 6'h19;
   localparam logic [15:0] SEQ1_DEFAULT = 16'h0043;
   // ******************************
   // timing
   // ******************************
   localparam int CLK_KHZ = 25000;
   localparam int STARTUP_MS = 300;
   localparam int FAST_MS = 50;
   localparam int SHUTDOWN_MS = 350;
   localparam int CAL_MS = STARTUP_MS - FAST_MS + 1;
   localparam int STEP_MS = FAST_MS / 2;
   localparam int SHUT_STEP_MS = SHUTDOWN_MS / 15;
   localparam int CAL_CYC = CAL_MS * CLK_KHZ;
   localparam int STEP_CYC = STEP_MS * CLK_KHZ / 17;
   localparam int SHUT_CYC = SHUT_STEP_MS * CLK_KHZ;

   // irq bits: 0 start-up done, 1 shutdown done, 2 aborted
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } av_req_t;
endpackage

// >>> hdl/step_timer.sv
// step wait counter for the sequencer
// assumes start pulses come from the same clock
`timescale 1ns/1ps
module step_timer
   import seq_ctl_pkg::*;
#(
   parameter int WIDTH = 24
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [WIDTH-1:0] cycles,
   output logic done
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic running;
      logic done;
   } tmr_t;
   tmr_t st, next_st;

   // count down, one-cycle done when the wait expires
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.count = cycles;
         next_st.running = 1'b1;
      end else if (st.running) begin
         if (st.count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            next_st.running = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.count = st.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign done = st.done;
endmodule

// >>> hdl/seq_ctl.sv
// sequencer control: start-up, fast start-up, shutdown, soft reset, identity
// assumes an Avalon-MM master with waitrequest; host supplies the master clock
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - default start-up lasts about 300 ms
// - running flag high while sequence executes
// - start-up calibrates and retains correction
// - patched start-up with correction under 50ms
// - soft reset restores default steps, drops correction
// - default shutdown lasts about 350 ms
// - write to address zero resets registers
// - address zero reads identity code
module seq_ctl
   import seq_ctl_pkg::*;
#(
   parameter logic [15:0] IDENTITY = 16'h5a31, // arbitrary value
   parameter int CAL_CYCLES = CAL_CYC,
   parameter int STEP_CYCLES = STEP_CYC,
   parameter int SHUT_CYCLES = SHUT_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   output logic sequence_running_flag,
   output logic offset_correction_valid
);
   // ******************************
   // state
   // ******************************
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_STEP = 4'b0010,
      S_WAIT = 4'b0100,
      S_ACK = 4'b1000
   } seq_state_t;

   typedef struct packed {
      seq_state_t fsm;
      logic ack;
      logic wreq;
      logic [31:0] rdata;
      logic sequencer_enable;
      logic [5:0] step_edit_index;
      logic [15:0] seq1;
      logic [15:0] seq2;
      logic [5:0] launch_step_index;
      logic [5:0] step;
      logic [STEPS-1:0] dummy;
      logic cal_done;
      logic running;
      logic is_shut;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
   } ctl_t;
   ctl_t st, next_st;

   logic tmr_start;
   logic [23:0] tmr_cycles;
   logic tmr_done;
   logic bus_wr;
   logic bus_rd;
   logic [2:0] events;

   step_timer #(.WIDTH(24)) u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .start(tmr_start),
      .cycles(tmr_cycles),
      .done(tmr_done)
   );

   // ******************************
   // next state
   // ******************************
   // one wait state per access keeps read data registered
   assign bus_wr = write && !st.ack;
   assign bus_rd = read && !st.ack;

   always_comb begin
      next_st = st;
      tmr_start = 1'b0;
      tmr_cycles = STEP_CYCLES[23:0];
      events = 3'b000;
      next_st.ack = bus_wr || bus_rd;
      // sequencer walk
      unique case (st.fsm)
         S_IDLE: begin
         end
         S_STEP: begin
            tmr_start = 1'b1;
            if (st.is_shut) begin
               tmr_cycles = SHUT_CYCLES[23:0];
            end else if (st.step == CAL_STEP && !st.dummy[CAL_STEP]) begin
               tmr_cycles = CAL_CYCLES[23:0];
            end else if (st.step == CAL_STEP && !st.cal_done) begin
               tmr_cycles = CAL_CYCLES[23:0]; // dummy without correction still slow
            end
            next_st.fsm = S_WAIT;
         end
         S_WAIT: begin
            if (tmr_done) begin
               if (st.step == CAL_STEP && !st.dummy[CAL_STEP] && !st.is_shut) begin
                  next_st.cal_done = 1'b1;
               end
               if ((!st.is_shut && st.step == SHUT_INDEX - 6'd1)
                   || (st.is_shut && st.step == 6'(STEPS - 1))) begin
                  next_st.fsm = S_ACK;
               end else begin
                  next_st.step = st.step + 6'd1;
                  next_st.fsm = S_STEP;
               end
            end
         end
         S_ACK: begin
            next_st.running = 1'b0;
            events[st.is_shut ? 1 : 0] = 1'b1;
            next_st.fsm = S_IDLE;
         end
         default: next_st.fsm = S_IDLE;
      endcase
      // register writes
      if (bus_wr) begin
         unique case (address)
            ADDR_SEQ0: begin
               next_st.sequencer_enable = writedata[SEQ_ENA_BIT];
               next_st.step_edit_index = writedata[5:0];
            end
            ADDR_SEQ1: begin
               next_st.seq1 = writedata[15:0];
               if (st.step_edit_index < 6'(STEPS)) begin
                  next_st.dummy[st.step_edit_index] =
                     (writedata[7:0] == DUMMY_ADDR);
               end
            end
            ADDR_SEQ2: next_st.seq2 = writedata[15:0];
            ADDR_SEQ3: begin
               if (writedata[ABORT_BIT]) begin
                  if (st.running) begin
                     events[2] = 1'b1;
                  end
                  next_st.running = 1'b0;
                  next_st.fsm = S_IDLE;
               end else if (writedata[LAUNCH_BIT] && st.sequencer_enable
                            && !st.running) begin
                  next_st.launch_step_index = writedata[5:0];
                  next_st.step = writedata[5:0];
                  next_st.is_shut = (writedata[5:0] >= SHUT_INDEX);
                  next_st.running = 1'b1;
                  next_st.fsm = S_STEP;
               end
            end
            ADDR_IRQ: next_st.status = st.status & ~writedata[2:0];
            ADDR_MASK: next_st.mask = writedata[2:0];
            default: begin
            end
         endcase
      end
      // register reads
      next_st.rdata = '0;
      if (bus_rd) begin
         unique case (address)
            ADDR_IDENT: next_st.rdata = {16'h0000, IDENTITY};
            ADDR_SEQ0: next_st.rdata = {23'h0, st.sequencer_enable, 2'b00,
                                        st.step_edit_index};
            ADDR_SEQ1: next_st.rdata = {16'h0000, st.seq1};
            ADDR_SEQ2: next_st.rdata = {16'h0000, st.seq2};
            ADDR_SEQ3: next_st.rdata = {26'h0, st.launch_step_index};
            ADDR_STAT: next_st.rdata = {31'h0, st.running};
            ADDR_IRQ: next_st.rdata = {29'h0, st.status};
            ADDR_MASK: next_st.rdata = {29'h0, st.mask};
            ADDR_CAL: next_st.rdata = {31'h0, st.cal_done};
            default: next_st.rdata = '0;
         endcase
      end
      // read of status clears, a new event in the same cycle wins
      if (bus_rd && address == ADDR_IRQ) begin
         next_st.status = 3'b000;
      end
      next_st.status = next_st.status | events;
      next_st.irq = |(next_st.status & next_st.mask);
      // soft reset: every field default except the bus ack, step timer left running, steps restored, correction lost
      if (bus_wr && address == ADDR_IDENT) begin
         next_st = '0;
         next_st.fsm = S_IDLE;
         next_st.seq1 = SEQ1_DEFAULT;
         next_st.ack = 1'b1;
      end
      // waitrequest gets its own flip-flop, so the pin carries no inverter
      next_st.wreq = !next_st.ack;
   end

   // ******************************
   // registers
   // ******************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st <= '0;
         st.fsm <= S_IDLE;
         st.seq1 <= SEQ1_DEFAULT;
         st.wreq <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign readdata = st.rdata;
   assign waitrequest = st.wreq;
   assign irq = st.irq;
   assign sequence_running_flag = st.running;
   assign offset_correction_valid = st.cal_done;
endmodule

// >>> dv/seq_ctl_sva.sv
// checker for the seq_ctl bus answer and sequencer flags
// assumes it is bound onto the seq_ctl ports, one clock
`timescale 1ns/1ps
module seq_ctl_sva
   import seq_ctl_pkg::*;
#(
   parameter logic [15:0] IDENTITY = 16'h5a31,
   parameter int CAL_CYCLES = 20,
   parameter int STEP_CYCLES = 3,
   parameter int SHUT_CYCLES = 5
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic irq,
   input wire logic sequence_running_flag,
   input wire logic offset_correction_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // generous ceiling: every step plus calibration plus bus slack
   localparam int LIMIT = CAL_CYCLES + 40 * (STEP_CYCLES + SHUT_CYCLES) + 80;
   logic ena;
   int run_cyc;
   wire logic take = (read || write) && waitrequest;
   wire logic wtake = write && waitrequest;
   wire logic srst = wtake && address == ADDR_IDENT;
   wire logic launch = wtake && address == ADDR_SEQ3 && writedata[LAUNCH_BIT] &&
      !writedata[ABORT_BIT] && ena && !sequence_running_flag;
   // shadow of the enable bit; soft reset drops it too
   always_ff @(posedge clk) begin
      if (!reset_n || srst) ena <= 1'b0;
      else if (wtake && address == ADDR_SEQ0) ena <= writedata[SEQ_ENA_BIT];
   end
   // length of the current run
   always_ff @(posedge clk) run_cyc <= sequence_running_flag ? run_cyc + 1 : 0;
   sequence s_ack;
      !waitrequest ##1 waitrequest;
   endsequence
   AST_ACK: assert property (take |=> s_ack)
      else $error("bus answer not one cycle");
   AST_IDLE_RD: assert property (waitrequest |-> readdata == 32'h0)
      else $error("read data outside answer");
   AST_ID: assert property (read && waitrequest && address == ADDR_IDENT |=>
      readdata == {16'h0000, IDENTITY}) else $error("identity wrong");
   AST_LAUNCH: assert property (launch |=> sequence_running_flag)
      else $error("busy late after launch");
   AST_RISE: assert property ($rose(sequence_running_flag) |->
      $past(wtake && address == ADDR_SEQ3)) else $error("busy without launch");
   AST_SRST: assert property (srst |-> ##[1:2] !offset_correction_valid && !irq)
      else $error("soft reset kept state");
   AST_LEN: assert property (run_cyc <= LIMIT)
      else $error("routine too long");
   AST_CAL: assert property ($rose(offset_correction_valid) |->
      sequence_running_flag || $past(sequence_running_flag)) else $error("stray correction");
   AST_KEEP: assert property (offset_correction_valid && !srst |=>
      offset_correction_valid) else $error("correction lost");
endmodule
bind seq_ctl seq_ctl_sva #(.IDENTITY(IDENTITY), .CAL_CYCLES(CAL_CYCLES),
   .STEP_CYCLES(STEP_CYCLES), .SHUT_CYCLES(SHUT_CYCLES)) i_seq_ctl_sva (.clk(clk),
   .reset_n(reset_n), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
   .sequence_running_flag(sequence_running_flag),
   .offset_correction_valid(offset_correction_valid));

// >>> dv/host_model.sv
// host model: avalon master that runs the preset routines
// assumes the block shares its clock
`timescale 1ns/1ps
module host_model
   import seq_ctl_pkg::*;
(
   input wire logic clk,
   output av_req_t req,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   int n_late = 0;
   int cyc = 0;
   initial req = '0;
   always @(posedge clk) cyc <= cyc + 1;
   // one transfer held until waitrequest is seen low, then an idle edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int k;
      k = 0;
      req <= '{a, !w, w, d};
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 64);
      q = readdata;
      if (k == 64) begin
         n_late++;
         $display("unexpected at %0t: %h vs %h", $time, a, 32'h0);
      end
      req <= '0;
      @(posedge clk);
   endtask
   // launch, poll busy at once, then until it clears
   task automatic run(input logic [15:0] ctl3, output logic first, output int len);
      logic [31:0] q;
      logic [31:0] dq;
      int t0;
      xfer(1, ADDR_SEQ3, {16'h0, ctl3}, q);
      t0 = cyc;
      xfer(0, ADDR_STAT, 0, q);
      first = q[0];
      // the converter write has its own answer word so the busy poll is not cut short
      if (ctl3[5:0] == 6'h0) xfer(1, 8'h84, 0, dq);
      for (int i = 0; i < 400 && q[0] === 1'b1; i++) xfer(0, ADDR_STAT, 0, q);
      // a routine that never ends counts as a mismatch
      if (q[0] !== 1'b0) begin
         n_late++;
         $display("unexpected at %0t: %h vs %h", $time, q, 32'h0);
      end
      len = cyc - t0;
   endtask
   task automatic start_up(input logic fast, output logic first, output int len);
      logic [31:0] q;
      xfer(1, ADDR_SEQ0, fast ? 32'h111 : 32'h100, q);
      if (fast) begin
         xfer(1, ADDR_SEQ1, 32'h00ff, q);
         xfer(1, ADDR_SEQ2, 32'h0, q);
      end
      run(16'h0100, first, len);
   endtask
endmodule

// >>> dv/seq_ctl_tb.sv
// self-checking bench for seq_ctl driven by the host model
// assumes shortened calibration and step counts
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module seq_ctl_tb
   import seq_ctl_pkg::*;
;
   localparam logic [15:0] ID = 16'h3c7e; // arbitrary value
   localparam int CAL = 20;
   localparam int STEP = 3;
   localparam int SHUT = 5;
   logic clk = 0;
   logic reset_n = 0;
   av_req_t req;
   logic [31:0] readdata, q, m;
   logic waitrequest, irq, busy, ocv, first;
   int n_errors = 0, num_checks = 0, t_norm, t_fast, t_x;
   always #20 clk = ~clk;
   host_model i_host_model (.clk(clk), .req(req), .readdata(readdata),
      .waitrequest(waitrequest));
   seq_ctl #(.IDENTITY(ID), .CAL_CYCLES(CAL), .STEP_CYCLES(STEP), .SHUT_CYCLES(SHUT))
   i_seq_ctl (.clk(clk), .reset_n(reset_n), .address(req.address), .read(req.read),
      .write(req.write), .writedata(req.writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .sequence_running_flag(busy),
      .offset_correction_valid(ocv));
   // shortest believable start-up in cycles
   function automatic int min_len(input logic fast);
      return 24 * STEP + (fast ? 0 : CAL);
   endfunction
   task automatic conclude();
      n_errors += i_host_model.n_late;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // hang guard, far beyond the whole sequence
   initial begin
      #(40 * 20000);
      n_errors++;
      conclude();
   end
   initial begin
      q = $urandom(59);
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // identity, soft reset with random data, unmapped read
      i_host_model.xfer(1, ADDR_IDENT, $urandom, q);
      i_host_model.xfer(0, ADDR_IDENT, 0, q);
      `CHK(q, {16'h0, ID})
      i_host_model.xfer(0, {2'b11, 6'($urandom)}, 0, q);
      `CHK(q, 32'h0)
      repeat (4) begin
         m = $urandom & 32'h7;
         i_host_model.xfer(1, ADDR_MASK, m, q);
         i_host_model.xfer(0, ADDR_MASK, 0, q);
         `CHK(q[2:0], m[2:0])
      end
      // masked start-up, then unmask, then read-clear
      i_host_model.xfer(1, ADDR_MASK, 0, q);
      i_host_model.start_up(0, first, t_norm);
      `CHK(first, 1'b1)
      `CHK(ocv, 1'b1)
      `CHK(irq, 1'b0)
      `CHK(t_norm >= min_len(0), 1'b1)
      i_host_model.xfer(1, ADDR_MASK, 32'h1, q);
      `CHK(irq, 1'b1)
      i_host_model.xfer(0, ADDR_IRQ, 0, q);
      `CHK(q[0], 1'b1)
      @(posedge clk);
      `CHK(irq, 1'b0)
      // patched start-up reuses the stored correction
      i_host_model.start_up(1, first, t_fast);
      `CHK(first, 1'b1)
      `CHK(t_fast >= min_len(1) && t_norm - t_fast >= CAL - 6, 1'b1)
      i_host_model.run(16'h0119, first, t_x);
      `CHK(t_x >= 15 * SHUT, 1'b1)
      i_host_model.xfer(0, ADDR_IRQ, 0, q);
      `CHK(q[1:0], 2'b11)
      // launch then abort at once: flag drops, abort event is latched
      i_host_model.xfer(1, ADDR_SEQ3, 32'h100, q);
      `CHK(busy, 1'b1)
      i_host_model.xfer(1, ADDR_SEQ3, 32'h200, q);
      `CHK(busy, 1'b0)
      i_host_model.xfer(0, ADDR_IRQ, 0, q);
      `CHK(q[2], 1'b1)
      // soft reset drops correction, mask and enable
      i_host_model.xfer(1, ADDR_IDENT, $urandom, q);
      `CHK(ocv, 1'b0)
      i_host_model.xfer(0, ADDR_MASK, 0, q);
      `CHK(q, 32'h0)
      i_host_model.run(16'h0100, first, t_x);
      `CHK(first, 1'b0)
      i_host_model.start_up(1, first, t_x);
      `CHK(t_x >= min_len(0), 1'b1)
      conclude();
   end
endmodule
